// [design/qdsi_bank.sv]
// Four input latches and four output latches of the quad DAC.
`timescale 1ns/10ps
`include "qdsi_consts.svh"
module qdsi_bank (
	input wire logic core_clk, // System clock.
	input wire logic rstn, // Synchronous reset, active low.
	qdsi_latch_if.bank lif // Write and update requests.
);
	import qdsi_pkg::*;

	qdsi_code_t in_q [4];
	qdsi_code_t in_d [4];
	qdsi_code_t out_q [4];
	qdsi_code_t out_d [4];

	////////////////////////////////////////////////////////////////////////
	// One channel per loop pass; a write lands in its own channel only.
	for (genvar c = 0; c < 4; c++) begin : g_ch
		// An update in the write cycle passes the fresh code straight through.
		always_comb begin
			in_d[c] = in_q[c];
			if (lif.wr_en && lif.wr_ch == qdsi_ch_t'(c)) begin
				in_d[c] = lif.wr_code;
			end
			out_d[c] = out_q[c];
			if (lif.upd_all || (lif.upd_one && lif.upd_ch == qdsi_ch_t'(c))) begin
				out_d[c] = in_d[c];
			end
		end

		// Power-on clear of both latch levels.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				in_q[c] <= `QDSI_CODE_RST;
				out_q[c] <= `QDSI_CODE_RST;
			end else begin
				in_q[c] <= in_d[c];
				out_q[c] <= out_d[c];
			end
		end
		assign lif.out_code[c] = out_q[c];
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_all_update: assert property (lif.upd_all && !lif.wr_en |=>
		out_q[0] == $past(in_q[0]) && out_q[1] == $past(in_q[1]) &&
		out_q[2] == $past(in_q[2]) && out_q[3] == $past(in_q[3]))
		else $error("simultaneous update missed a channel");
	a_other_kept: assert property (lif.wr_en && lif.wr_ch == 2'b00 |=>
		$stable(in_q[1]) && $stable(in_q[2]) && $stable(in_q[3]) &&
		in_q[0] == $past(lif.wr_code))
		else $error("write to channel A disturbed another latch");
endmodule : qdsi_bank

// [design/qdsi_top.sv]
// Serial input and control logic of a quad 12-bit voltage-output DAC.
// Behaviour
// - Chip select must be low; frame sync and data ignored while it is high.
// - After frame sync falls, shift data on falling serial clock, MSB first.
// - After sixteen bits or early frame sync rise, load the addressed latch.
// - After sixteen bits, update the output on the next rising serial clock.
// - Reset clears every latch bit to zero.
// - Top four bits are control, lower twelve bits are the DAC code.
// - Two top bits select channel A, B, C or D as 00 to 11.
// - Bit 12 set selects fast settling, clear selects slow settling.
// - Bit 13 set enters power-down, clear selects normal operation.
// - In power-down all amplifiers are disabled.
// - Code is unsigned 0 to 4095; output is 2 times reference code/4096.
// - Low pulse on latch update loads all four outputs together.
// - Hardware power-down is active low; held high keeps DACs enabled.
`timescale 1ns/10ps
`include "qdsi_consts.svh"
module qdsi_top (
	input wire logic core_clk, // System clock, 50 MHz.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic cs_n, // Chip select, active low.
	input wire logic frame_sync, // Frame start on falling edge.
	input wire logic sclk, // Serial clock from the host.
	input wire logic sdin, // Serial data, MSB first.
	input wire logic latch_update_n, // Update all outputs, active low.
	input wire logic hw_power_down_n, // Hardware power-down, active low.
	output qdsi_pkg::qdsi_code_t dac_code [4], // Output codes A to D.
	output logic fast_mode, // Fast settling selected.
	output logic sw_power_down, // Power-down bit of the last word.
	output logic amp_enable, // Amplifiers enabled.
	output logic frame_active // A word is being received.
);
	import qdsi_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.
	logic [5:0] pin_raw;
	logic [5:0] s1_q;
	logic [5:0] s1_d;
	logic [5:0] s2_q;
	logic [5:0] s2_d;
	logic [5:0] s3_q;
	logic [5:0] s3_d;
	logic cs_lo;
	logic fs_fall;
	logic fs_rise;
	logic sck_fall;
	logic sck_rise;
	logic ld_fall;
	logic sdin_s;
	logic hw_pd_s;

	// All host pins are asynchronous to core_clk.
	assign pin_raw = {hw_power_down_n, latch_update_n, sdin, sclk, frame_sync, cs_n};

	// Two stages before use; the third stage only keeps the previous level.
	always_comb begin
		s1_d = pin_raw;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	// Pins idle high except the data line, so reset to high avoids false edges.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s1_q <= `QDSI_PIN_RST;
			s2_q <= `QDSI_PIN_RST;
			s3_q <= `QDSI_PIN_RST;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// Edges are seen only between the second and third stages.
	assign cs_lo = !s2_q[`QDSI_PIN_CS];
	assign fs_fall = s3_q[`QDSI_PIN_FS] && !s2_q[`QDSI_PIN_FS];
	assign fs_rise = !s3_q[`QDSI_PIN_FS] && s2_q[`QDSI_PIN_FS];
	assign sck_fall = s3_q[`QDSI_PIN_SCK] && !s2_q[`QDSI_PIN_SCK];
	assign sck_rise = !s3_q[`QDSI_PIN_SCK] && s2_q[`QDSI_PIN_SCK];
	assign ld_fall = s3_q[`QDSI_PIN_LD] && !s2_q[`QDSI_PIN_LD];
	assign sdin_s = s2_q[`QDSI_PIN_SD];
	assign hw_pd_s = s2_q[`QDSI_PIN_PD];

	////////////////////////////////////////////////////////////////////////
	// Word field decoding, used for the write and update requests.
	function automatic qdsi_ch_t word_ch(input qdsi_word_t w);
		word_ch = {w[`QDSI_ADDR_HI], w[`QDSI_ADDR_LO]};
	endfunction : word_ch

	function automatic qdsi_code_t word_code(input qdsi_word_t w);
		word_code = w[`QDSI_CODE_MSB:0];
	endfunction : word_code

	////////////////////////////////////////////////////////////////////////
	// Frame state machine and shift register.
	qdsi_state_e state_q;
	qdsi_state_e state_d;
	qdsi_word_t sh_q;
	qdsi_word_t sh_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	qdsi_ch_t ch_q;
	qdsi_ch_t ch_d;
	logic spd_q;
	logic spd_d;
	logic pwr_q;
	logic pwr_d;
	logic amp_q;
	logic amp_d;
	qdsi_word_t word_sel;
	logic wr_en;
	logic upd_one;

	qdsi_latch_if lif ();

	// A falling clock in the same cycle as a rise of frame sync counts first,
	// so the word that caused the last edge is never cut short.
	always_comb begin
		state_d = state_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		ch_d = ch_q;
		spd_d = spd_q;
		pwr_d = pwr_q;
		wr_en = 1'b0;
		upd_one = 1'b0;
		word_sel = sh_q;
		if (sck_fall) begin
			word_sel = {sh_q[`QDSI_WORD_BITS-2:0], sdin_s};
		end
		if (!cs_lo) begin
			// A word already loaded still reaches its output when the
			// host deselects without a rising clock edge.
			upd_one = (state_q == QDSI_WAIT_RISE);
			state_d = QDSI_IDLE;
			cnt_d = `QDSI_CNT_RST;
		end else begin
			unique case (state_q)
				QDSI_IDLE: begin
					if (fs_fall) begin
						state_d = QDSI_SHIFT;
						cnt_d = `QDSI_CNT_RST;
					end
				end
				QDSI_SHIFT: begin
					if (sck_fall) begin
						sh_d = word_sel;
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == `QDSI_LAST_BIT) begin
							wr_en = 1'b1;
							state_d = QDSI_WAIT_RISE;
						end
					end else if (fs_rise) begin
						// A short word loads whatever the register holds.
						wr_en = (cnt_q != `QDSI_CNT_RST);
						upd_one = wr_en;
						state_d = QDSI_IDLE;
					end
				end
				QDSI_WAIT_RISE: begin
					if (sck_rise || fs_rise) begin
						upd_one = 1'b1;
						state_d = QDSI_IDLE;
					end
				end
				default: begin
					state_d = QDSI_IDLE;
				end
			endcase
		end
		if (wr_en) begin
			ch_d = word_ch(word_sel);
			pwr_d = word_sel[`QDSI_PWR_BIT];
			spd_d = word_sel[`QDSI_SPD_BIT];
		end
		// Either the control bit or the pin turns every amplifier off.
		amp_d = hw_pd_s && !pwr_d;
	end

	// Power-on state: all latches, control bits and counters at zero.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_q <= QDSI_IDLE;
			sh_q <= `QDSI_WORD_RST;
			cnt_q <= `QDSI_CNT_RST;
			ch_q <= 2'b00;
			spd_q <= 1'b0;
			pwr_q <= 1'b0;
			amp_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			ch_q <= ch_d;
			spd_q <= spd_d;
			pwr_q <= pwr_d;
			amp_q <= amp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Latch bank requests; top two bits steer, low twelve are the code.
	assign lif.wr_en = wr_en;
	assign lif.wr_ch = word_ch(word_sel);
	assign lif.wr_code = word_code(word_sel);
	assign lif.upd_one = upd_one;
	assign lif.upd_ch = wr_en ? word_ch(word_sel) : ch_q;
	assign lif.upd_all = ld_fall;

	qdsi_bank u_bank (
		.core_clk(core_clk),
		.rstn(rstn),
		.lif(lif.bank)
	);

	// Codes leave as plain unsigned binary for the resistor string.
	assign dac_code = lif.out_code;
	assign fast_mode = spd_q;
	assign sw_power_down = pwr_q;
	assign amp_enable = amp_q;
	assign frame_active = (state_q != QDSI_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_cs_ignores_frame: assert property (!cs_lo |=> state_q == QDSI_IDLE && cnt_q == 4'h0)
		else $error("frame state moved while chip select was high");
	a_shift_msb_first: assert property (cs_lo && state_q == QDSI_SHIFT && sck_fall |=>
		sh_q[0] == $past(sdin_s) && sh_q[15:1] == $past(sh_q[14:0]))
		else $error("serial bit not shifted in at the low end");
	a_sixteen_loads: assert property (cs_lo && state_q == QDSI_SHIFT && sck_fall &&
		cnt_q == 4'hF |-> lif.wr_en ##1 state_q == QDSI_WAIT_RISE)
		else $error("sixteenth bit did not load the latch");
	a_rise_updates: assert property (cs_lo && state_q == QDSI_WAIT_RISE && sck_rise |->
		lif.upd_one && lif.upd_ch == ch_q ##1 state_q == QDSI_IDLE)
		else $error("rising clock after the word did not update the output");
	a_reset_clears: assert property (disable iff (1'b0) !rstn |=>
		!spd_q && !pwr_q && sh_q == 16'h0000 && dac_code[0] == 12'h000)
		else $error("reset left a latch bit set");
	a_addr_decode: assert property (lif.wr_en |=> ch_q == $past(word_sel[15:14]))
		else $error("channel address not taken from the two top bits");
	a_speed_bit: assert property (lif.wr_en |=> fast_mode == $past(word_sel[12]))
		else $error("speed bit not taken from bit 12");
	a_power_bit: assert property (lif.wr_en && word_sel[13] |=> ##1 !amp_enable)
		else $error("power-down bit did not disable the amplifiers");
	a_hw_power_down: assert property (!hw_pd_s |=> !amp_enable)
		else $error("hardware power-down did not disable the amplifiers");
endmodule : qdsi_top

// [include/qdsi_consts.svh]
// Bit positions, reset values and link figures of the quad DAC serial input.
`ifndef QDSI_CONSTS_SVH
`define QDSI_CONSTS_SVH
`define QDSI_WORD_BITS 16
`define QDSI_LAST_BIT 4'hF
`define QDSI_ADDR_HI 15
`define QDSI_ADDR_LO 14
`define QDSI_PWR_BIT 13
`define QDSI_SPD_BIT 12
`define QDSI_CODE_MSB 11
`define QDSI_CODE_RST 12'h000
`define QDSI_WORD_RST 16'h0000
`define QDSI_CNT_RST 4'h0
`define QDSI_PIN_CS 0
`define QDSI_PIN_FS 1
`define QDSI_PIN_SCK 2
`define QDSI_PIN_SD 3
`define QDSI_PIN_LD 4
`define QDSI_PIN_PD 5
`define QDSI_PIN_RST 6'h3F
`define QDSI_SCLK_MAX_MHZ 20
`endif

// [include/qdsi_latch_if.sv]
// Interface between the serial front end and the DAC latch bank.
`timescale 1ns/10ps
interface qdsi_latch_if;
	import qdsi_pkg::*;
	logic wr_en;
	qdsi_ch_t wr_ch;
	qdsi_code_t wr_code;
	logic upd_one;
	qdsi_ch_t upd_ch;
	logic upd_all;
	qdsi_code_t out_code [4];
	modport ctrl (output wr_en, wr_ch, wr_code, upd_one, upd_ch, upd_all, input out_code);
	modport bank (input wr_en, wr_ch, wr_code, upd_one, upd_ch, upd_all, output out_code);
endinterface : qdsi_latch_if

// [include/qdsi_pkg.sv]
// Types shared by the quad DAC serial input modules.
package qdsi_pkg;
	typedef logic [11:0] qdsi_code_t;
	typedef logic [1:0] qdsi_ch_t;
	typedef logic [15:0] qdsi_word_t;
	typedef enum logic [1:0] {
		QDSI_IDLE = 2'b00,
		QDSI_SHIFT = 2'b01,
		QDSI_WAIT_RISE = 2'b10
	} qdsi_state_e;
endpackage : qdsi_pkg

// [tb/qdsi_host_model.sv]
// Behavioural host that drives the serial link of the quad DAC.
`timescale 1ns/10ps
module qdsi_host_model (
	input wire logic core_clk, // System clock, paces the link.
	output logic cs_n, // Chip select, active low.
	output logic frame_sync, // Frame sync.
	output logic sclk, // Serial clock, 160 ns period, 320 ns for the ninth bit.
	output logic sdin // Serial data.
);
	// All link pins idle high except data, so no false edge is seen at reset release.
	initial begin
		cs_n = 1'b1;
		frame_sync = 1'b1;
		sclk = 1'b1;
		sdin = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// Wait a number of system clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// Send the top nb bits of w; mode 1 leaves chip select high, mode 2 ties it low.
	task automatic send(input logic [15:0] w, input int nb, input int mode);
		cs_n <= (mode == 1);
		tick(3);
		frame_sync <= 1'b0;
		tick(4);
		// Data changes on the rising clock, so it is steady around each fall.
		for (int i = 0; i < nb; i++) begin
			sdin <= w[15 - i];
			tick(i == 8 ? 12 : 4);
			sclk <= 1'b0;
			tick(4);
			sclk <= 1'b1;
		end
		tick(4);
		frame_sync <= 1'b1;
		sdin <= ~sdin; // A released line must not keep showing the last bit.
		tick(4);
		cs_n <= (mode != 2);
		tick(6);
	endtask : send
endmodule : qdsi_host_model

// [tb/quad_dac_serial_input_test.sv]
// Self-checking bench of the quad DAC serial input.
`timescale 1ns/10ps
module quad_dac_serial_input_test;
	import qdsi_pkg::*;
	typedef struct packed {
		qdsi_word_t word;
		qdsi_ch_t ch;
		qdsi_code_t code;
		logic fast;
		logic pd;
	} qdsi_row_s;
	logic core_clk;
	logic rstn;
	logic cs_n;
	logic frame_sync;
	logic sclk;
	logic sdin;
	logic latch_update_n;
	logic hw_power_down_n;
	qdsi_code_t dac_code [4];
	logic fast_mode;
	logic sw_power_down;
	logic amp_enable;
	logic frame_active;
	qdsi_code_t exp_code [4];
	int fails = 0;
	int check_count = 0;
	// Every channel, both speed values and both power values appear once at least.
	qdsi_row_s rows [4] = '{
		'{16'h1ABC, 2'h0, 12'hABC, 1'b1, 1'b0},
		'{16'h6123, 2'h1, 12'h123, 1'b0, 1'b1},
		'{16'h9FFF, 2'h2, 12'hFFF, 1'b1, 1'b0},
		'{16'hC5A5, 2'h3, 12'h5A5, 1'b0, 1'b0}};
	////////////////////////////////////////////////////////////
	qdsi_top i_dut (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .frame_sync(frame_sync),
		.sclk(sclk), .sdin(sdin), .latch_update_n(latch_update_n),
		.hw_power_down_n(hw_power_down_n), .dac_code(dac_code), .fast_mode(fast_mode),
		.sw_power_down(sw_power_down), .amp_enable(amp_enable), .frame_active(frame_active));
	qdsi_host_model i_host (.core_clk(core_clk), .cs_n(cs_n), .frame_sync(frame_sync),
		.sclk(sclk), .sdin(sdin));
	// 50 MHz system clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic chk_code(input qdsi_code_t got, input qdsi_code_t exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected code at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_code
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected flag at %0t: got %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// All four outputs are compared, so a write that spills into a neighbour shows.
	task automatic check_all();
		for (int c = 0; c < 4; c++) begin
			chk_code(dac_code[c], exp_code[c]);
		end
	endtask : check_all
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	// The tests need about 1400 cycles; the margin is wide.
	initial begin
		tick(20000);
		fails++;
		stop_test();
	end
	////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		latch_update_n = 1'b1;
		hw_power_down_n = 1'b1;
		for (int c = 0; c < 4; c++) begin
			exp_code[c] = 12'h000;
		end
		tick(12);
		rstn <= 1'b1;
		tick(6);
		check_all();
		chk_bit(fast_mode, 1'b0);
		chk_bit(sw_power_down, 1'b0);
		chk_bit(amp_enable, 1'b1);
		// Ordinary words, one row each.
		foreach (rows[i]) begin
			i_host.send(rows[i].word, 16, 0);
			exp_code[rows[i].ch] = rows[i].code;
			check_all();
			chk_bit(fast_mode, rows[i].fast);
			chk_bit(sw_power_down, rows[i].pd);
			chk_bit(amp_enable, !rows[i].pd);
			chk_bit(frame_active, 1'b0);
		end
		// A frame sent while chip select is high must change nothing.
		i_host.send(16'h4FFF, 16, 1);
		check_all();
		// Three-wire mode, chip select low across both words.
		i_host.send(16'h8765, 16, 2);
		exp_code[2] = 12'h765;
		i_host.send(16'hC300, 16, 2);
		exp_code[3] = 12'h300;
		check_all();
		// Early frame end after eight bits loads the low byte unaligned.
		i_host.send(16'hA500, 8, 0);
		exp_code[0] = 12'h0A5;
		check_all();
		chk_bit(sw_power_down, 1'b0);
		// The host's sixteenth fall is seen at edge 141 and its rise at edge 145, so a
		// latch update pulse placed between them is the only thing that can move B early.
		fork
			i_host.send(16'h4456, 16, 0);
			begin
				tick(141);
				latch_update_n <= 1'b0;
				tick(2);
				@(negedge core_clk);
				chk_code(dac_code[1], 12'h123);
				chk_bit(frame_active, 1'b1);
				tick(2);
				@(negedge core_clk);
				chk_code(dac_code[1], 12'h456);
				tick(1);
				latch_update_n <= 1'b1;
			end
		join
		exp_code[1] = 12'h456;
		tick(6);
		check_all();
		// Hardware power-down turns the amplifiers off and back on.
		hw_power_down_n <= 1'b0;
		tick(6);
		chk_bit(amp_enable, 1'b0);
		hw_power_down_n <= 1'b1;
		tick(6);
		chk_bit(amp_enable, 1'b1);
		// A reset in mid-run must clear latches that now hold non-zero codes.
		rstn <= 1'b0;
		tick(3);
		rstn <= 1'b1;
		tick(6);
		for (int c = 0; c < 4; c++) begin
			exp_code[c] = 12'h000;
		end
		check_all();
		chk_bit(frame_active, 1'b0);
		chk_bit(sw_power_down, 1'b0);
		stop_test();
	end
endmodule : quad_dac_serial_input_test
